// ===== rtl/ms_tick.sv
// file: divider giving a one-cycle enable pulse every period cycles
// assumes: single clock domain, async active-low reset
`timescale 1ns/1ps
module ms_tick #(
  parameter int period = 100000
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // enable pulse out
  output logic tick
);
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic next_tick;

  // count down and pulse on wrap
  always_comb begin
    next_tick = 1'b0;
    next_cnt = cnt - 32'h1;
    if (cnt == 32'h0) begin
      next_cnt = 32'(period - 1);
      next_tick = 1'b1;
    end
  end

  // register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 32'h0;
      tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule : ms_tick

// ===== rtl/ovw_pkg.sv
// package: constants for the input over-voltage warning response sequencer
// assumes: imported by the sequencer top and the self-checking bench
package ovw_pkg;
  // ==========================================================
  // command codes
  localparam logic [7:0] cmd_user_scratch_string = 8'hb0;
  localparam logic [7:0] cmd_input_overvoltage_warning_action = 8'hc4;
  // ==========================================================
  // field positions of the action byte
  localparam int act_hi = 7;
  localparam int act_lo = 6;
  localparam int retry_hi = 5;
  localparam int retry_lo = 3;
  localparam int delay_hi = 2;
  localparam int delay_lo = 0;
  // action codes
  localparam logic [1:0] act_ignore = 2'h0;
  localparam logic [1:0] act_keep_running = 2'h1;
  localparam logic [1:0] act_disable_retry = 2'h2;
  localparam logic [1:0] act_latch_off = 2'h3;
  // retry codes
  localparam logic [2:0] retry_none = 3'h0;
  localparam logic [2:0] retry_forever = 3'h7;
  // reset values
  localparam logic [7:0] action_reset = 8'h00;
  localparam logic [127:0] scratch_reset = 128'h0;
  // ==========================================================
  // timing
  localparam int clk_hz = 100_000_000;
  localparam int base_unit_ms = 1;
  localparam int base_unit_cycles = clk_hz / 1000 * base_unit_ms;
  localparam int unit_scale_10 = 10;
  localparam int unit_scale_100 = 100;
  localparam int unit_scale_1000 = 1000;
endpackage : ovw_pkg

// ===== rtl/vin_ov_warn_fault_response.sv
// file: input over-voltage warning response sequencer with user scratch string
// assumes: command decoder upstream gives write strobes with command code and data,
// and converter state inputs come from the same clock domain except the warning pin
`timescale 1ns/1ps
module vin_ov_warn_fault_response
  import ovw_pkg::*;
#(
  parameter int unit_cycles = base_unit_cycles
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // register access from the command decoder
  input wire logic wr_en,
  input wire logic [7:0] wr_cmd,
  input wire logic [127:0] wr_data,
  // warning pin, clearing events, forced-stop fault input and input unit select
  input wire logic ov_warn_pin,
  input wire logic clear_status,
  input wire logic clear_faults,
  input wire logic output_commanded_on,
  input wire logic other_fault_shutdown,
  input wire logic [1:0] vin_unit_sel,
  // register read-back and status
  output logic [7:0] input_overvoltage_warning_action,
  output logic [127:0] user_scratch_string,
  output logic output_enable,
  output logic fault_latched,
  output logic [2:0] attempts_made
);
  // ==========================================================
  // sequencer states
  typedef enum logic [4:0] {
    st_run = 5'b00001,
    st_delay = 5'b00010,
    st_off_wait = 5'b00100,
    st_restart = 5'b01000,
    st_latched = 5'b10000
  } state_t;

  state_t state;
  state_t next_state;
  logic warn_s1;
  logic warn;
  logic cmd_on_d;
  logic ms_en;
  logic [7:0] next_action;
  logic [127:0] next_scratch;
  logic [17:0] timer;
  logic [17:0] next_timer;
  logic [9:0] sub;
  logic [9:0] next_sub;
  logic [2:0] next_attempts;
  logic next_output_enable;
  logic next_fault_latched;
  logic clear_evt;
  logic [1:0] act;
  logic [2:0] retry;
  logic [17:0] delay_units;
  logic [9:0] unit_ms;

  // ==========================================================
  // one millisecond base tick
  ms_tick #(.period(unit_cycles)) u_tick (
    .mclk(mclk),
    .rstn(rstn),
    .tick(ms_en)
  );

  // two-flop synchroniser for the warning pin, plus a one-cycle delayed copy of the on command
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      warn_s1 <= 1'b0;
      warn <= 1'b0;
      cmd_on_d <= 1'b1; // idle level of the command, so no false edge after reset
    end else begin
      warn_s1 <= ov_warn_pin;
      warn <= warn_s1;
      cmd_on_d <= output_commanded_on;
    end
  end

  // ==========================================================
  // register file
  always_comb begin
    next_action = input_overvoltage_warning_action;
    next_scratch = user_scratch_string;
    if (wr_en && wr_cmd == cmd_input_overvoltage_warning_action) begin
      next_action = wr_data[7:0];
    end
    if (wr_en && wr_cmd == cmd_user_scratch_string) begin
      next_scratch = wr_data;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      input_overvoltage_warning_action <= action_reset;
      user_scratch_string <= scratch_reset;
    end else begin
      input_overvoltage_warning_action <= next_action;
      user_scratch_string <= next_scratch;
    end
  end

  // field decode and delay length
  assign act = input_overvoltage_warning_action[act_hi:act_lo];
  assign retry = input_overvoltage_warning_action[retry_hi:retry_lo];
  assign delay_units = 18'(1) << input_overvoltage_warning_action[delay_hi:delay_lo];

  // unit selection in milliseconds
  always_comb begin
    unit_ms = 10'(base_unit_ms);
    unique case (vin_unit_sel)
      2'h0: unit_ms = 10'(base_unit_ms);
      2'h1: unit_ms = 10'(unit_scale_10);
      2'h2: unit_ms = 10'(unit_scale_100);
      2'h3: unit_ms = 10'(unit_scale_1000);
    endcase
  end

  // off-then-on command, clear events
  assign clear_evt = clear_status || clear_faults || (output_commanded_on && !cmd_on_d);

  // ==========================================================
  // sequencer next state
  always_comb begin
    next_state = state;
    next_timer = timer;
    next_sub = sub;
    next_attempts = attempts_made;
    next_output_enable = output_enable;
    next_fault_latched = fault_latched;
    // timebase: sub counts ms within a unit, timer counts units
    if (ms_en && timer != 18'h0) begin
      if (sub + 10'h1 >= unit_ms) begin
        next_sub = 10'h0;
        next_timer = timer - 18'h1;
      end else begin
        next_sub = sub + 10'h1;
      end
    end
    unique case (state)
      st_run: begin
        next_output_enable = output_commanded_on;
        if (warn && output_commanded_on) begin
          unique case (act)
            act_ignore: next_state = st_run;
            act_keep_running: begin
              next_state = st_delay;
              next_timer = delay_units;
              next_sub = 10'h0;
            end
            act_disable_retry: begin
              next_output_enable = 1'b0;
              next_fault_latched = 1'b1;
              next_state = (retry == retry_none) ? st_latched : st_off_wait;
              next_timer = delay_units;
              next_sub = 10'h0;
            end
            act_latch_off: begin
              next_output_enable = 1'b0;
              next_fault_latched = 1'b1;
              next_state = st_latched;
            end
          endcase
        end
      end
      st_delay: begin
        if (!warn) begin
          next_state = st_run;
          next_timer = 18'h0;
        end else if (timer == 18'h0) begin
          next_output_enable = 1'b0;
          next_fault_latched = 1'b1;
          next_state = (retry == retry_none) ? st_latched : st_off_wait;
          next_timer = delay_units;
          next_sub = 10'h0;
        end
      end
      st_off_wait: begin
        next_output_enable = 1'b0;
        if (timer == 18'h0) begin
          next_state = st_restart;
          next_output_enable = 1'b1;
          next_attempts = (attempts_made == 3'h7) ? attempts_made : attempts_made + 3'h1;
          next_timer = delay_units;
          next_sub = 10'h0;
        end
      end
      st_restart: begin
        if (!warn) begin
          next_state = st_run;
          next_attempts = 3'h0;
          next_fault_latched = 1'b0;
          next_timer = 18'h0;
        end else if (timer == 18'h0) begin
          next_output_enable = 1'b0;
          if (retry != retry_forever && attempts_made >= retry) begin
            next_state = st_latched;
          end else begin
            next_state = st_restart;
            next_output_enable = 1'b1;
            next_attempts = (attempts_made == 3'h7) ? attempts_made : attempts_made + 3'h1;
            next_timer = delay_units;
            next_sub = 10'h0;
          end
        end
      end
      st_latched: begin
        next_output_enable = 1'b0;
      end
    endcase
    // clearing and forced stop win over the sequence
    if (clear_evt) begin
      next_state = st_run;
      next_attempts = 3'h0;
      next_timer = 18'h0;
      next_sub = 10'h0;
      next_fault_latched = 1'b0;
      next_output_enable = output_commanded_on;
    end else if (!output_commanded_on || other_fault_shutdown) begin
      next_output_enable = 1'b0;
      if (state != st_latched && state != st_run) begin
        next_state = st_latched;
      end
    end
  end

  // sequencer registers; bias loss is the async reset
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= st_run;
      timer <= 18'h0;
      sub <= 10'h0;
      attempts_made <= 3'h0;
      output_enable <= 1'b0;
      fault_latched <= 1'b0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      sub <= next_sub;
      attempts_made <= next_attempts;
      output_enable <= next_output_enable;
      fault_latched <= next_fault_latched;
    end
  end

  // ==========================================================
  // checks
  property p_ignore_runs;
    @(posedge mclk) disable iff (!rstn)
      (state == st_run && act == act_ignore && output_commanded_on && cmd_on_d
       && !clear_evt && !other_fault_shutdown) |=> output_enable;
  endproperty
  a_ignore_runs: assert property (p_ignore_runs) else $error("ignore dropped output");

  property p_disable_now;
    @(posedge mclk) disable iff (!rstn)
      (state == st_run && warn && output_commanded_on && act[1] && !clear_evt)
      |=> !output_enable && fault_latched;
  endproperty
  a_disable_now: assert property (p_disable_now) else $error("disable was late");

  property p_latched_off;
    @(posedge mclk) disable iff (!rstn)
      (state == st_latched && !clear_evt) |=> !output_enable;
  endproperty
  a_latched_off: assert property (p_latched_off) else $error("latched with output on");

  property p_clear;
    @(posedge mclk) disable iff (!rstn)
      clear_evt |=> state == st_run && attempts_made == 3'h0 && !fault_latched;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not reset");

  property p_no_retry;
    @(posedge mclk) disable iff (!rstn)
      (retry == retry_none && state == st_latched) |-> attempts_made == 3'h0
        || $past(retry) != retry_none;
  endproperty
  a_no_retry: assert property (p_no_retry) else $error("retried with zero count");

  property p_attempt_cap;
    @(posedge mclk) disable iff (!rstn)
      (retry != retry_forever && $stable(retry) && state == st_restart) |-> attempts_made <= retry;
  endproperty
  a_attempt_cap: assert property (p_attempt_cap) else $error("too many attempts");

  property p_timer_load;
    @(posedge mclk) disable iff (!rstn)
      (state == st_off_wait && timer == 18'h0 && !clear_evt && output_commanded_on
       && !other_fault_shutdown) |=> state == st_restart && timer == $past(delay_units);
  endproperty
  a_timer_load: assert property (p_timer_load) else $error("restart timer wrong");

  property p_scratch;
    @(posedge mclk) disable iff (!rstn)
      (wr_en && wr_cmd == cmd_user_scratch_string) |=> user_scratch_string == $past(wr_data);
  endproperty
  a_scratch: assert property (p_scratch) else $error("scratch readback wrong");

  property p_forced_off;
    @(posedge mclk) disable iff (!rstn)
      (other_fault_shutdown && !clear_evt) |=> !output_enable;
  endproperty
  a_forced_off: assert property (p_forced_off) else $error("shutdown ignored");

  c_delay: cover property (@(posedge mclk) disable iff (!rstn) state == st_delay ##1 state == st_off_wait);
  c_restart: cover property (@(posedge mclk) disable iff (!rstn) state == st_restart ##1 state == st_run);
  c_latched: cover property (@(posedge mclk) disable iff (!rstn) state == st_restart ##1 state == st_latched);
endmodule : vin_ov_warn_fault_response

// ===== sim/host_model.sv
// file: bus host model issuing register writes to the sequencer
// assumes: one clock; writes launched just after rising mclk
`timescale 1ns/1ps
module host_model (
  // clock
  input wire logic mclk,
  // write request
  output logic wr_en,
  output logic [7:0] wr_cmd,
  output logic [127:0] wr_data
);
  // ==========
  // idle bus at time zero
  initial begin
    wr_en = 1'b0;
    wr_cmd = 8'h00;
    wr_data = 128'h0;
  end
  // one-cycle strobe; released lines show inverted values, never stale ones
  task automatic write(input logic [7:0] cmd, input logic [127:0] data);
    @(posedge mclk);
    wr_en <= 1'b1;
    wr_cmd <= cmd;
    wr_data <= data;
    @(posedge mclk);
    wr_en <= 1'b0;
    wr_cmd <= ~cmd;
    wr_data <= ~data;
  endtask : write
endmodule : host_model

// ===== sim/tb.sv
// file: self-checking bench for the warning response sequencer
// assumes: sequencer built with unit_cycles of 10; host_model issues writes
`timescale 1ns/1ps
module tb;
  import ovw_pkg::*;
  // ==========
  // signals
  localparam int ucyc = 10;
  logic mclk, rstn, ov_warn_pin, clear_status, clear_faults;
  logic output_commanded_on, other_fault_shutdown, wr_en;
  logic output_enable, fault_latched;
  logic [1:0] vin_unit_sel;
  logic [2:0] attempts_made;
  logic [7:0] wr_cmd, action;
  logic [127:0] wr_data, scratch;
  int miscompares, n_compared, cycles, t, r;
  // ==========
  // far side and block under test
  host_model host (.mclk(mclk), .wr_en(wr_en), .wr_cmd(wr_cmd), .wr_data(wr_data));
  vin_ov_warn_fault_response #(.unit_cycles(ucyc)) dut (
    .mclk(mclk), .rstn(rstn), .wr_en(wr_en), .wr_cmd(wr_cmd), .wr_data(wr_data),
    .ov_warn_pin(ov_warn_pin), .clear_status(clear_status), .clear_faults(clear_faults),
    .output_commanded_on(output_commanded_on), .other_fault_shutdown(other_fault_shutdown),
    .vin_unit_sel(vin_unit_sel), .input_overvoltage_warning_action(action),
    .user_scratch_string(scratch), .output_enable(output_enable),
    .fault_latched(fault_latched), .attempts_made(attempts_made));
  // ==========
  // clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares++;
      give_verdict();
    end
  end
  // ==========
  // helpers
  task automatic check(input logic [127:0] got, input logic [127:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // a count outside lo..hi is reported as itself
  task automatic near(input int n, input int lo, input int hi);
    check((n >= lo && n <= hi) ? lo : n, lo);
  endtask : near
  // wait on falling edges for the output enable to reach v, max cycles at most
  task automatic wait_oe(input logic v, input int max, output int n);
    n = 0;
    while (output_enable !== v && n < max) begin
      @(negedge mclk);
      n++;
    end
  endtask : wait_oe
  // wait for the restart counter to move
  task automatic next_step(input int max, output int n);
    logic [2:0] a;
    a = attempts_made;
    n = 0;
    while (attempts_made === a && n < max) begin
      @(negedge mclk);
      n++;
    end
  endtask : next_step
  task automatic warn(input logic v);
    @(posedge mclk);
    ov_warn_pin <= v;
  endtask : warn
  task automatic set_action(input logic [7:0] a);
    host.write(cmd_input_overvoltage_warning_action, {120'h0, a});
  endtask : set_action
  // clearing event: 0 status bit, 1 clear-all, 2 off then on, 3 reset
  task automatic clear(input int k);
    @(posedge mclk);
    case (k)
      0: clear_status <= 1'b1;
      2: output_commanded_on <= 1'b0;
      3: rstn <= 1'b0;
      default: clear_faults <= 1'b1;
    endcase
    @(posedge mclk);
    clear_status <= 1'b0;
    clear_faults <= 1'b0;
    output_commanded_on <= 1'b1;
    rstn <= 1'b1;
  endtask : clear
  // ==========
  // scenarios
  task automatic t_regs();
    check(action, action_reset);
    check(scratch, scratch_reset);
    host.write(cmd_user_scratch_string, 128'h00112233445566778899aabbccddeeff);
    host.write(8'hb1, 128'h5a);
    set_action(8'h91);
    @(negedge mclk);
    check(scratch, 128'h00112233445566778899aabbccddeeff);
    check(action, 8'h91);
  endtask : t_regs
  task automatic t_ignore();
    set_action({act_ignore, 6'h3f});
    warn(1'b1);
    wait_oe(1'b0, 200, t);
    check(t, 200);
    check(fault_latched, 1'b0);
    warn(1'b0);
  endtask : t_ignore
  // keep running for the coded delay at each unit, then shut down
  task automatic t_keep();
    int sel[8] = '{0, 0, 0, 0, 0, 1, 2, 3};
    int d[8] = '{0, 1, 2, 3, 7, 0, 0, 0};
    int scale[4] = '{1, unit_scale_10, unit_scale_100, unit_scale_1000};
    int exp;
    for (int i = 0; i < 8; i++) begin
      set_action({act_keep_running, retry_none, 3'(d[i])});
      vin_unit_sel <= 2'(sel[i]);
      exp = (1 << d[i]) * scale[sel[i]] * ucyc;
      warn(1'b1);
      wait_oe(1'b0, exp + 40, t);
      near(t, exp - 10, exp + 14);
      check(fault_latched, 1'b1);
      warn(1'b0);
      clear(1);
      wait_oe(1'b1, 10, t);
    end
  endtask : t_keep
  // latch-off holds the output off until each kind of clearing event
  task automatic t_latch();
    for (int k = 0; k < 4; k++) begin
      set_action({act_latch_off, 6'h0});
      warn(1'b1);
      wait_oe(1'b0, 20, t);
      warn(1'b0);
      wait_oe(1'b1, 50, t);
      check(t, 50);
      clear(k);
      wait_oe(1'b1, 10, t);
      check({fault_latched, output_enable}, 2'b01);
    end
  endtask : t_latch
  // immediate shutdown, n restarts, then off for good; counter starts afresh
  task automatic t_retry();
    for (int n = 0; n < 7; n++) begin
      set_action({act_disable_retry, 3'(n), 3'h0});
      vin_unit_sel <= 2'h0;
      warn(1'b1);
      wait_oe(1'b0, 20, t);
      near(t, 0, 5);
      repeat (n * 25 + 40) @(negedge mclk);
      check({fault_latched, output_enable, attempts_made}, {2'b10, 3'(n)});
      wait_oe(1'b1, 30, t);
      check(t, 30);
      warn(1'b0);
      clear(1);
      wait_oe(1'b1, 10, t);
      check(attempts_made, 3'h0);
    end
  endtask : t_retry
  // keep-running hands over to retries; a restart without warning recovers
  task automatic t_recover();
    set_action({act_keep_running, 3'h2, 3'h0});
    warn(1'b1);
    wait_oe(1'b0, 40, t);
    near(t, 4, 18);
    next_step(60, t);
    check({fault_latched, output_enable, attempts_made}, 5'h19);
    warn(1'b0);
    repeat (6) @(negedge mclk);
    check({fault_latched, output_enable, attempts_made}, 5'h08);
  endtask : t_recover
  // endless restarts at the coded spacing until commanded off or another fault
  task automatic t_forever();
    for (int k = 0; k < 2; k++) begin
      set_action({act_disable_retry, retry_forever, 3'h1});
      warn(1'b1);
      next_step(60, t);
      next_step(60, t);
      near(t, 16, 24);
      r = 0;
      repeat (5) begin
        next_step(60, t);
        r += (t < 60);
      end
      check(r, 5);
      // the counter stops at seven; a limited count would have latched off by now
      repeat (60) @(negedge mclk);
      check({fault_latched, output_enable}, 2'b11);
      @(posedge mclk);
      if (k == 0) output_commanded_on <= 1'b0;
      else other_fault_shutdown <= 1'b1;
      repeat (3) @(negedge mclk);
      wait_oe(1'b1, 100, t);
      check(t, 100);
      check(fault_latched, 1'b1);
      warn(1'b0);
      other_fault_shutdown <= 1'b0;
      clear(k + 1);
      wait_oe(1'b1, 10, t);
      check(fault_latched, 1'b0);
    end
  endtask : t_forever
  // ==========
  // verdict and main sequence
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    rstn = 1'b0;
    ov_warn_pin = 1'b0;
    clear_status = 1'b0;
    clear_faults = 1'b0;
    output_commanded_on = 1'b1;
    other_fault_shutdown = 1'b0;
    vin_unit_sel = 2'h0;
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    t_regs();
    t_ignore();
    t_keep();
    t_latch();
    t_retry();
    t_recover();
    t_forever();
    give_verdict();
  end
endmodule : tb
